// ### hw/rhs_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module rhs_serial_port
    import rhs_pkg::*;
#(
    parameter int CLK_HZ = 100_000_000,
    parameter int DEPTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd,
    input wire logic cts,
    input wire logic dsr,
    input wire logic dcd,
    output logic txd,
    output logic rts,
    output logic dtr
);

localparam int PW = $clog2(DEPTH);
localparam int DW = 24;

// --------------------------------
// Helpers
// --------------------------------
function automatic logic [DW-1:0] baud_div(input logic [2:0] sel);
    baud_div = DW'(CLK_HZ / (OVS * BAUD_TBL[sel]));
endfunction

function automatic logic [11:0] mk_frame(
    input logic [7:0] d,
    input logic eight,
    input logic [1:0] par
);
    logic [11:0] f;
    logic [7:0] m;
    f = 12'hFFF;
    m = eight ? d : {1'b0, d[6:0]};
    f[0] = 1'b0;
    f[7:1] = d[6:0];
    if (eight) begin
        f[8] = d[7];
    end
    if (par != PAR_NONE) begin
        f[eight ? 9 : 8] = (par == PAR_ODD) ^ (^m);
    end
    mk_frame = f;
endfunction

// --------------------------------
// Declarations
// --------------------------------
rhs_st_t st_ff;
logic [31:0] cfg_ff;
logic [31:0] prdata_ff;
logic [3:0] s1_ff, s2_ff, s3_ff, pin_ff;
logic [DW-1:0] bcnt_ff;
logic rx_act_ff, rx_done_ff;
logic [3:0] rx_tick_ff, rx_bit_ff;
logic [11:0] rx_sh_ff;
logic [7:0] mem [DEPTH];
logic [PW-1:0] wr_ff, rd_ff;
logic [PW:0] cnt_ff;
logic ovr_ff, par_ff, syn_ff;
logic rts_ff, rts_pin_ff, dtr_ff;
logic [7:0] tx_hold_ff, tx_char_ff;
logic tx_full_ff, tx_last_ff;
logic [1:0] term_ff;
logic [3:0] eidx_ff;
logic [11:0] tx_frame_ff;
logic [3:0] tx_tick_ff, tx_bit_ff;

logic bt, eight, hp, two;
logic [1:0] par;
logic [3:0] nd, rx_stop, tx_stop;
logic rxd_f, cts_ok, dsr_ok, dcd_ok;
logic [7:0] rx_d;
logic rx_perr, rx_ev, acc, push, pop, is_lf, full;
logic err_any, avail, take, lst, tx_end, fin;
logic [7:0] ch;
logic [119:0] msg;
logic [31:0] stat_w;
logic wr_en, tx_wr;

// --------------------------------
// Frame shape
// --------------------------------
assign eight = cfg_ff[CF_EIGHT];
assign par = cfg_ff[CF_PAR +: 2];
assign hp = par != PAR_NONE;
assign two = cfg_ff[CF_TWO] && !(eight && hp);
assign nd = eight ? NBIT8 : NBIT7;
assign rx_stop = nd + {3'h0, hp} + 4'h1;
assign tx_stop = rx_stop + {3'h0, two};

// --------------------------------
// Pin synchronisers
// --------------------------------
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        s1_ff <= 4'h1;
        s2_ff <= 4'h1;
        s3_ff <= 4'h1;
    end else begin
        s1_ff <= {dcd, dsr, cts, rxd};
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
    end
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pin_ff <= 4'h1;
    end else begin
        for (int i = 0; i < 4; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
                pin_ff[i] <= s3_ff[i];
            end
        end
    end
end

assign rxd_f = pin_ff[0];
assign cts_ok = pin_ff[1] | cfg_ff[CF_FCTS];
assign dsr_ok = pin_ff[2] | cfg_ff[CF_FDSR];
assign dcd_ok = pin_ff[3] | cfg_ff[CF_FDCD];

// --------------------------------
// Oversampling tick
// --------------------------------
// One tick for both directions; half duplex means they never compete
assign bt = bcnt_ff >= baud_div(cfg_ff[CF_BAUD +: 3]) - DW'(1);

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        bcnt_ff <= '0;
    end else if (bt) begin
        bcnt_ff <= '0;
    end else begin
        bcnt_ff <= bcnt_ff + DW'(1);
    end
end

// --------------------------------
// Receiver
// --------------------------------
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rx_act_ff <= 1'b0;
        rx_done_ff <= 1'b0;
        rx_tick_ff <= '0;
        rx_bit_ff <= '0;
        rx_sh_ff <= '0;
    end else begin
        rx_done_ff <= 1'b0;
        if (!rx_act_ff) begin
            if (st_ff == S_RX && !rxd_f) begin
                rx_act_ff <= 1'b1;
                rx_tick_ff <= 4'(MID - 1);
                rx_bit_ff <= '0;
            end
        end else if (bt) begin
            if (rx_tick_ff != 4'h0) begin
                rx_tick_ff <= rx_tick_ff - 4'h1;
            end else begin
                rx_sh_ff[rx_bit_ff] <= rxd_f;
                rx_tick_ff <= 4'(OVS - 1);
                rx_bit_ff <= rx_bit_ff + 4'h1;
                if (rx_bit_ff == 4'h0 && rxd_f) begin
                    rx_act_ff <= 1'b0;
                end else if (rx_bit_ff == rx_stop) begin
                    rx_act_ff <= 1'b0;
                    rx_done_ff <= 1'b1;
                end
            end
        end
    end
end

// Stop bit level is not checked; a bad stop still yields a character
assign rx_d = eight ? rx_sh_ff[8:1] : {1'b0, rx_sh_ff[7:1]};
assign rx_perr = hp && ((^rx_d ^ rx_sh_ff[eight ? 9 : 8]) != (par == PAR_ODD));
assign rx_ev = rx_done_ff && st_ff == S_RX;
assign acc = rx_ev && dcd_ok;
assign full = cnt_ff == (PW+1)'(DEPTH);
assign push = acc && !full;
assign is_lf = rx_d == CH_LF;

// --------------------------------
// Message buffer
// --------------------------------
// Pointers wrap naturally, so DEPTH must be a power of two
always_ff @(posedge pclk) begin
    if (push) begin
        mem[wr_ff] <= rx_d;
    end
end

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        wr_ff <= '0;
        rd_ff <= '0;
        cnt_ff <= '0;
    end else if (fin) begin
        wr_ff <= '0;
        rd_ff <= '0;
        cnt_ff <= '0;
    end else begin
        if (push) begin
            wr_ff <= wr_ff + PW'(1);
        end
        if (pop) begin
            rd_ff <= rd_ff + PW'(1);
        end
        cnt_ff <= cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end
end

// --------------------------------
// Error flags
// --------------------------------
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ovr_ff <= 1'b0;
        par_ff <= 1'b0;
        syn_ff <= 1'b0;
    end else if (fin) begin
        ovr_ff <= 1'b0;
        par_ff <= 1'b0;
        syn_ff <= 1'b0;
    end else begin
        if (rx_ev && !dcd_ok) begin
            syn_ff <= 1'b1;
        end
        if (acc && rx_perr) begin
            par_ff <= 1'b1;
        end
        if (acc && full) begin
            ovr_ff <= 1'b1;
        end
    end
end

assign err_any = ovr_ff | par_ff | syn_ff;

// --------------------------------
// Control state machine
// --------------------------------
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        st_ff <= S_RX;
        rts_ff <= 1'b0;
    end else begin
        unique case (st_ff)
            S_RX: begin
                if (acc && is_lf) begin
                    st_ff <= S_HOLD;
                    rts_ff <= 1'b1;
                end
            end
            S_HOLD: begin
                if (avail) begin
                    st_ff <= S_WAIT;
                end
            end
            S_WAIT: begin
                if (cts_ok && dsr_ok) begin
                    st_ff <= S_SEND;
                end
            end
            S_SEND: begin
                if (tx_end) begin
                    st_ff <= tx_last_ff ? S_RX : S_HOLD;
                    if (tx_last_ff) begin
                        rts_ff <= 1'b0;
                    end
                end
            end
            default: begin
                st_ff <= S_RX;
            end
        endcase
    end
end

// --------------------------------
// Reply source
// --------------------------------
// Priority overrun, parity, syntax; only one error reply is sent
assign msg = ovr_ff ? MSG_OVR : (par_ff ? MSG_PAR : MSG_SYN);

always_comb begin
    int len;
    len = ovr_ff ? LEN_OVR : LEN_PS;
    ch = tx_hold_ff;
    lst = 1'b0;
    if (err_any) begin
        ch = msg[(len - 1 - int'(eidx_ff)) * 8 +: 8];
        lst = int'(eidx_ff) == len - 1;
    end else if (tx_full_ff) begin
        ch = tx_hold_ff;
    end else if (term_ff != 2'h0) begin
        ch = (term_ff == TERM_CR) ? CH_CR : CH_LF;
        lst = term_ff == TERM_LF;
    end
end

assign avail = err_any | tx_full_ff | (term_ff != 2'h0);
assign take = st_ff == S_HOLD && avail;
assign wr_en = psel && penable && pwrite;
assign tx_wr = wr_en && paddr == A_TXD;

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_hold_ff <= '0;
        tx_full_ff <= 1'b0;
        term_ff <= '0;
        eidx_ff <= '0;
        tx_char_ff <= '0;
        tx_last_ff <= 1'b0;
    end else begin
        if (fin) begin
            tx_full_ff <= 1'b0;
            term_ff <= '0;
            eidx_ff <= '0;
        end else if (take) begin
            tx_char_ff <= ch;
            tx_last_ff <= lst;
            if (err_any) begin
                eidx_ff <= eidx_ff + 4'h1;
            end else if (tx_full_ff) begin
                tx_full_ff <= 1'b0;
            end else begin
                term_ff <= (term_ff == TERM_CR) ? TERM_LF : 2'h0;
            end
        end
        // Software write wins over the end-of-reply clear
        if (tx_wr && pwdata[TX_TERM] && term_ff == 2'h0) begin
            term_ff <= TERM_CR;
        end else if (tx_wr && !pwdata[TX_TERM] && !tx_full_ff) begin
            tx_hold_ff <= pwdata[7:0];
            tx_full_ff <= 1'b1;
        end
    end
end

// --------------------------------
// Transmitter
// --------------------------------
assign tx_end = st_ff == S_SEND && bt && tx_tick_ff == 4'h0 && tx_bit_ff == tx_stop;
assign fin = tx_end && tx_last_ff;

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        tx_frame_ff <= 12'hFFF;
        tx_tick_ff <= '0;
        tx_bit_ff <= '0;
    end else if (st_ff == S_WAIT && cts_ok && dsr_ok) begin
        tx_frame_ff <= mk_frame(tx_char_ff, eight, par);
        tx_tick_ff <= 4'(OVS - 1);
        tx_bit_ff <= '0;
    end else if (st_ff == S_SEND && bt) begin
        if (tx_tick_ff != 4'h0) begin
            tx_tick_ff <= tx_tick_ff - 4'h1;
        end else begin
            tx_tick_ff <= 4'(OVS - 1);
            tx_bit_ff <= tx_bit_ff + 4'h1;
            tx_frame_ff <= {1'b1, tx_frame_ff[11:1]};
        end
    end
end

// --------------------------------
// Handshake outputs
// --------------------------------
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        dtr_ff <= 1'b0;
        rts_pin_ff <= 1'b0;
    end else begin
        dtr_ff <= 1'b1;
        rts_pin_ff <= rts_ff ^ cfg_ff[CF_INV];
    end
end

assign txd = tx_frame_ff[0];
assign rts = rts_pin_ff;
assign dtr = dtr_ff;

// --------------------------------
// APB slave
// --------------------------------
always_comb begin
    stat_w = '0;
    stat_w[ST_MSG] = st_ff == S_HOLD && !err_any;
    stat_w[ST_OVR] = ovr_ff;
    stat_w[ST_PAR] = par_ff;
    stat_w[ST_SYN] = syn_ff;
    stat_w[ST_TXF] = tx_full_ff;
    stat_w[ST_RTS] = rts_ff;
    stat_w[ST_BUSY] = st_ff == S_WAIT || st_ff == S_SEND;
    stat_w[ST_CNT +: PW+1] = cnt_ff;
end

assign pop = psel && penable && !pwrite && paddr == A_RXD && cnt_ff != '0;

always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cfg_ff <= CFG_RST;
    end else if (wr_en && paddr == A_CFG) begin
        cfg_ff <= pwdata & CFG_MASK;
    end
end

// Read data is captured in the setup cycle so it comes from a flop
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_ff <= '0;
    end else if (psel && !penable) begin
        unique case (paddr)
            A_CFG: prdata_ff <= cfg_ff;
            A_STAT: prdata_ff <= stat_w;
            A_RXD: prdata_ff <= (cnt_ff != '0) ? {24'h0, mem[rd_ff]} : '0;
            default: prdata_ff <= '0;
        endcase
    end
end

assign prdata = prdata_ff;
assign pready = 1'b1;
assign pslverr = psel && penable && (pwrite ? !(paddr == A_CFG || paddr == A_TXD)
                                            : !(paddr == A_CFG || paddr == A_STAT
                                                || paddr == A_RXD));

endmodule // rhs_serial_port
`default_nettype wire

// ### hw/rhs_pkg.sv
// Notes on behaviour
// - DTR goes true once reset ends and stays true.
// - A start bit on receive data starts a full character, stored in the buffer.
// - Carrier detect is sampled per character; when false the character is dropped.
// - Characters are buffered until a line feed ends the message.
// - The line feed raises RTS as holdoff; the host waits for the full reply.
// - Each reply character waits for CTS and DSR true, tested once per character.
// - After the reply terminator RTS drops and reception resumes.
// - RTS stays negated from reset until the first line feed arrives.
// - The invert bit flips RTS polarity in every state.
// - Separate bits force DSR, CTS and DCD true regardless of the pin.
// - Eight selectable rates from 50 to 9600 baud, both directions.
// - Seven or eight data bits per character.
// - Even, odd or no parity; generated on send, checked on receive.
// - One or two stop bits; eight data bits with parity force one.
// - Half duplex: no reception during a reply, no sending while receiving.
// - Characters dropped for missing carrier cause the syntax error reply.
// - Buffer overflow causes the overrun error reply.
// - A byte with bad parity causes the parity error reply.
// - A lone line feed ends a message; every reply ends with CR LF.
package rhs_pkg;

    localparam logic [7:0] A_CFG = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_RXD = 8'h08;
    localparam logic [7:0] A_TXD = 8'h0C;

    localparam int CF_BAUD = 0;
    localparam int CF_EIGHT = 3;
    localparam int CF_PAR = 4;
    localparam int CF_TWO = 6;
    localparam int CF_FDSR = 7;
    localparam int CF_FCTS = 8;
    localparam int CF_FDCD = 9;
    localparam int CF_INV = 10;
    localparam logic [31:0] CFG_RST = 32'h0000_038F;
    localparam logic [31:0] CFG_MASK = 32'h0000_07FF;

    localparam int ST_MSG = 0;
    localparam int ST_OVR = 1;
    localparam int ST_PAR = 2;
    localparam int ST_SYN = 3;
    localparam int ST_TXF = 4;
    localparam int ST_RTS = 5;
    localparam int ST_BUSY = 6;
    localparam int ST_CNT = 8;
    localparam int TX_TERM = 8;

    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [3:0] NBIT8 = 4'h8;
    localparam logic [3:0] NBIT7 = 4'h7;

    localparam int OVS = 16;
    localparam int MID = 8;
    localparam int BAUD_TBL [8] = '{75, 50, 300, 600, 1200, 2400, 4800, 9600};

    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [119:0] MSG_OVR = "OVERRUN ERROR\r\n";
    localparam logic [119:0] MSG_PAR = "PARITY ERROR\r\n";
    localparam logic [119:0] MSG_SYN = "SYNTAX ERROR\r\n";
    localparam int LEN_OVR = 15;
    localparam int LEN_PS = 14;

    localparam logic [1:0] TERM_CR = 2'h1;
    localparam logic [1:0] TERM_LF = 2'h2;

    typedef enum logic [3:0] {
        S_RX = 4'h1,
        S_HOLD = 4'h2,
        S_WAIT = 4'h4,
        S_SEND = 4'h8
    } rhs_st_t;

endpackage

// ### verification/rhs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rhs_host_model (
    input wire logic pclk,
    input wire logic txd,
    input wire logic rts,
    output logic rxd,
    output logic cts,
    output logic dsr,
    output logic dcd
);
    // ----------------------------
    // Host side of the serial link
    // ----------------------------
    int bit_len = 80;
    int nd = 8;
    int pm = 0;
    int ns = 1;
    int perr = 0;
    logic flip = 1'b0;
    logic [7:0] rx_q[$];
    initial begin
        rxd = 1'b1;
        cts = 1'b1;
        dsr = 1'b1;
        dcd = 1'b1;
    end
    task automatic fmt(input int n, input int p, input int s, input logic f);
        nd = n;
        pm = p;
        ns = s;
        flip = f;
    endtask
    task automatic hs(input logic c, input logic d, input logic k);
        @(posedge pclk);
        cts <= c;
        dsr <= d;
        dcd <= k;
    endtask
    task automatic put(input logic v);
        @(posedge pclk);
        rxd <= v;
        repeat (bit_len - 1) @(posedge pclk);
    endtask
    task automatic send(input logic [7:0] ch);
        int i;
        logic p;
        // Bad parity only when a case asks for it
        p = ^ch[6:0] ^ (nd == 8 && ch[7]) ^ (pm == 2) ^ flip;
        for (i = 0; i < 40000 && rts; i++) @(posedge pclk);
        // Holdoff that never ends counts as a frame error
        perr += int'(rts !== 1'b0);
        put(1'b0);
        for (i = 0; i < nd; i++) put(ch[i]);
        if (pm != 0) put(p);
        repeat (ns) put(1'b1);
    endtask
    always begin : rx_loop
        logic [7:0] b;
        int k;
        @(negedge txd);
        b = 8'h00;
        repeat (bit_len / 2) @(posedge pclk);
        for (k = 0; k < nd; k++) begin
            repeat (bit_len) @(posedge pclk);
            b[k] = txd;
        end
        if (pm != 0) begin
            repeat (bit_len) @(posedge pclk);
            perr += int'(txd !== (^b ^ (pm == 2)));
        end
        repeat (bit_len) @(posedge pclk);
        perr += int'(txd !== 1'b1);
        rx_q.push_back(b);
    end
endmodule // rhs_host_model
`default_nettype wire

// ### verification/rhs_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rhs_chk
    import rhs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rxd,
    input wire logic cts,
    input wire logic dsr,
    input wire logic dcd,
    input wire logic txd,
    input wire logic rts,
    input wire logic dtr
);
    // -----------------------------
    // Shadow state and port checks
    // -----------------------------
    logic [10:0] cfg_ff;
    logic inv_q_ff;
    logic seen_ff;
    logic [9:0] age_ff;
    logic [3:0] stall_ff;
    logic cfg_wr;
    logic hs_ok;
    logic hold;
    logic map_ok;
    assign cfg_wr = psel && penable && pwrite && paddr == A_CFG;
    assign hs_ok = (cts || cfg_ff[CF_FCTS]) && (dsr || cfg_ff[CF_FDSR]);
    // Pin lags the config by one flop, hence the delayed copy
    assign hold = rts ^ inv_q_ff;
    assign map_ok = pwrite ? (paddr == A_CFG || paddr == A_TXD) :
        (paddr == A_CFG || paddr == A_STAT || paddr == A_RXD);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= CFG_RST[10:0];
            inv_q_ff <= 1'b0;
            seen_ff <= 1'b0;
            age_ff <= 10'h3FF;
            stall_ff <= 4'h0;
        end else begin
            cfg_ff <= cfg_wr ? pwdata[10:0] : cfg_ff;
            inv_q_ff <= cfg_ff[CF_INV];
            seen_ff <= seen_ff || !rxd;
            age_ff <= !rxd ? 10'h000 : age_ff + {9'h000, age_ff != 10'h3FF};
            stall_ff <= hs_ok ? 4'h0 : stall_ff + {3'h0, stall_ff != 4'hF};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence apb_access;
        psel && !penable ##1 psel && penable;
    endsequence
    sequence inv_flip;
        cfg_wr && pwdata[CF_INV] != cfg_ff[CF_INV];
    endsequence
    dtr_on_line_a: assert property ($past(presetn) |-> dtr)
        else $error("dtr not held true");
    rts_quiet_a: assert property (!seen_ff && !inv_q_ff |-> !rts)
        else $error("rts asserted before any message");
    hold_rise_a: assert property ($rose(hold) |-> age_ff < 10'h258)
        else $error("holdoff rose without recent receive traffic");
    hold_fall_a: assert property ($fell(hold) |-> $past(txd) && $past(txd, 40))
        else $error("holdoff dropped before stop bit finished");
    half_duplex_a: assert property (!txd |-> hold)
        else $error("transmit outside holdoff");
    tx_gate_a: assert property ($fell(txd) |-> stall_ff < 4'h8)
        else $error("start bit while handshake false");
    rts_invert_a: assert property (inv_flip |-> ##2 $changed(rts))
        else $error("rts did not follow invert bit");
    apb_ready_a: assert property (apb_access |-> pready)
        else $error("access phase not ready");
    apb_err_a: assert property (psel && penable |-> pslverr == !map_ok)
        else $error("slave error mismatch");
endmodule // rhs_chk
bind rhs_serial_port rhs_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts(cts), .dsr(dsr), .dcd(dcd),
    .txd(txd), .rts(rts), .dtr(dtr));
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module testbench
    import rhs_pkg::*;
;
    // ------------------------------
    // Stimulus, checks and verdict
    // ------------------------------
    typedef struct {
        logic [31:0] cfg;
        int nd;
        int pm;
        int ns;
        logic [7:0] ch;
        int bl;
    } rhs_row_t;
    rhs_row_t rows [4] = '{'{32'h0000_038F, 8, 0, 1, 8'h41, 80},
        '{32'h0000_0397, 7, 1, 1, 8'h4B, 80}, '{32'h0000_03AF, 8, 2, 1, 8'h5A, 80},
        '{32'h0000_03C6, 7, 0, 2, 8'h33, 160}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic rxd, cts, dsr, dcd, txd, rts, dtr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    int mismatches = 0;
    int cmp_count = 0;
    // Low clock figure keeps each bit at 80 cycles of 9600 baud
    rhs_serial_port #(.CLK_HZ(768_000), .DEPTH(4)) i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .cts(cts),
        .dsr(dsr), .dcd(dcd), .txd(txd), .rts(rts), .dtr(dtr));
    rhs_host_model i_host (.pclk(pclk), .txd(txd), .rts(rts), .rxd(rxd), .cts(cts),
        .dsr(dsr), .dcd(dcd));
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic fail(input string w);
        mismatches++;
        $display("unexpected stall in %s expected done seen timeout", w);
        tally_and_finish();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fail("apb");
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_rts(input logic v);
        int n;
        for (n = 0; n < 40000 && rts !== v; n++) @(posedge pclk);
        if (rts !== v) fail("rts");
        `CHK("rts", v, rts);
    endtask
    task automatic send_txd(input logic [31:0] d);
        int n;
        rdat = 32'h0000_0010;
        for (n = 0; n < 400 && rdat[ST_TXF] !== 1'b0; n++) apb(1'b0, A_STAT, 32'h0);
        if (rdat[ST_TXF] !== 1'b0) fail("txd holding");
        apb(1'b1, A_TXD, d);
    endtask
    task automatic reply(input logic [119:0] m, input int n);
        int i;
        for (i = 0; i < 60000 && i_host.rx_q.size() < n; i++) @(posedge pclk);
        if (i_host.rx_q.size() < n) fail("reply");
        for (i = 0; i < n; i++) `CHK("reply", m[8*(n-1-i) +: 8], i_host.rx_q[i]);
        `CHK("reply len", n, i_host.rx_q.size());
        `CHK("frame errors", 0, i_host.perr);
        i_host.rx_q.delete();
        wait_rts(1'b0);
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (8) @(posedge pclk);
        `CHK("dtr in reset", 1'b0, dtr);
        `CHK("txd idle", 1'b1, txd);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("dtr on line", 1'b1, dtr);
        `CHK("rts idle", 1'b0, rts);
        apb(1'b0, A_CFG, 32'h0);
        `CHK("cfg reset", CFG_RST, rdat);
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped err", 1'b1, rerr);
        `CHK("unmapped data", 32'h0000_0000, rdat);
        apb(1'b1, A_STAT, 32'h0);
        `CHK("status write err", 1'b1, rerr);
        apb(1'b1, A_CFG, CFG_RST | 32'h0000_0400);
        repeat (3) @(posedge pclk);
        `CHK("rts inverted", 1'b1, rts);
        apb(1'b1, A_CFG, CFG_RST);
        repeat (3) @(posedge pclk);
        `CHK("rts plain", 1'b0, rts);
        foreach (rows[k]) begin
            apb(1'b1, A_CFG, rows[k].cfg);
            i_host.bit_len = rows[k].bl;
            i_host.fmt(rows[k].nd, rows[k].pm, rows[k].ns, 1'b0);
            i_host.send(rows[k].ch);
            i_host.send(CH_LF);
            wait_rts(1'b1);
            apb(1'b0, A_STAT, 32'h0);
            `CHK("msg ready", 1'b1, rdat[ST_MSG]);
            `CHK("count", 3'h2, rdat[ST_CNT +: 3]);
            apb(1'b0, A_RXD, 32'h0);
            `CHK("rx char", rows[k].ch, rdat[7:0]);
            apb(1'b0, A_RXD, 32'h0);
            `CHK("rx lf", CH_LF, rdat[7:0]);
            send_txd({24'h000000, rows[k].ch});
            send_txd(32'h0000_0100);
            reply({96'h0, rows[k].ch, CH_CR, CH_LF}, 3);
        end
        i_host.bit_len = 80;
        // Host not ready: reply char must wait
        apb(1'b1, A_CFG, 32'h0000_008F);
        i_host.fmt(8, 0, 1, 1'b0);
        i_host.hs(1'b0, 1'b1, 1'b1);
        i_host.send(8'h51);
        i_host.send(CH_LF);
        wait_rts(1'b1);
        send_txd(32'h0000_0051);
        repeat (2000) @(posedge pclk);
        `CHK("gated reply", 0, i_host.rx_q.size());
        i_host.hs(1'b1, 1'b1, 1'b1);
        send_txd(32'h0000_0100);
        reply({96'h0, 8'h51, CH_CR, CH_LF}, 3);
        apb(1'b1, A_CFG, 32'h0000_018F);
        i_host.hs(1'b1, 1'b1, 1'b0);
        i_host.send(8'h41);
        i_host.hs(1'b1, 1'b1, 1'b1);
        i_host.send(CH_LF);
        reply(MSG_SYN, LEN_PS);
        apb(1'b1, A_CFG, 32'h0000_039F);
        i_host.fmt(8, 1, 1, 1'b1);
        i_host.send(8'h41);
        i_host.fmt(8, 1, 1, 1'b0);
        i_host.send(CH_LF);
        reply(MSG_PAR, LEN_PS);
        apb(1'b1, A_CFG, CFG_RST);
        i_host.fmt(8, 0, 1, 1'b0);
        repeat (5) i_host.send(8'h42);
        i_host.send(CH_LF);
        reply(MSG_OVR, LEN_OVR);
        // Reset during holdoff: rts must drop and stay low
        i_host.send(8'h43);
        i_host.send(CH_LF);
        wait_rts(1'b1);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK("dtr mid reset", 1'b0, dtr);
        `CHK("rts mid reset", 1'b0, rts);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("dtr after reset", 1'b1, dtr);
        `CHK("rts after reset", 1'b0, rts);
        apb(1'b0, A_STAT, 32'h0);
        `CHK("count after reset", 3'h0, rdat[ST_CNT +: 3]);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
